// ==== echo_suppress_duplex_config.sv ====
// echo suppressor and full-duplex criteria register bank with its decision logic
`timescale 1ns/10ps
`include "echo_duplex_consts.svh"

module doubletalk_ramp
#(
   parameter int STEPS = 7,
   parameter int ATTACK_CYCLES = 1000000,
   parameter int SLOW_CYCLES = 25000000,
   parameter int NORMAL_CYCLES = 2500000
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic engage,
   input wire logic [2:0] target,
   input wire logic normal_rate,
   output logic [2:0] level
);
   // full swing spread evenly over the code steps
   localparam logic [24:0] ATTACK_STEP =
      25'((ATTACK_CYCLES / STEPS) > 0 ? ATTACK_CYCLES / STEPS : 1);
   localparam logic [24:0] SLOW_STEP =
      25'((SLOW_CYCLES / STEPS) > 0 ? SLOW_CYCLES / STEPS : 1);
   localparam logic [24:0] NORMAL_STEP =
      25'((NORMAL_CYCLES / STEPS) > 0 ? NORMAL_CYCLES / STEPS : 1);

   echo_duplex_pkg::ramp_state_t state;
   echo_duplex_pkg::ramp_state_t next_state;
   logic [2:0] goal;
   logic [24:0] interval;

   always_comb
   begin
      next_state = state;
      goal = engage ? target : 3'h0;
      interval = normal_rate ? NORMAL_STEP : SLOW_STEP;
      if (state.level < goal)
      begin
         // attack toward the programmed depth
         if (state.count >= ATTACK_STEP - 25'h0000001)
         begin
            next_state.count = 25'h0000000;
            next_state.level = state.level + 3'h1; // R20
         end
         else
         begin
            next_state.count = state.count + 25'h0000001;
         end
      end
      else if (state.level > goal)
      begin
         // decay pace set by the selected ramp rate
         if (state.count >= interval - 25'h0000001)
         begin
            next_state.count = 25'h0000000;
            next_state.level = state.level - 3'h1; // R20
         end
         else
         begin
            next_state.count = state.count + 25'h0000001;
         end
      end
      else
      begin
         next_state.count = 25'h0000000;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign level = state.level;

endmodule : doubletalk_ramp

// one full-duplex criterion: depth test when noisy, asymptotic estimate when quiet
module duplex_criterion
(
   input wire logic [1:0] depth_code,
   input wire logic [1:0] noise_code,
   input wire logic [5:0] depth,
   input wire logic [7:0] noise,
   input wire logic asym_ok,
   output logic ok
);
   logic loud;
   logic deep;

   // reserved depth code falls back to the code-zero threshold
   function automatic logic [5:0] depth_decode(input logic [1:0] code);
      logic [5:0] thr;
      thr = 6'h18;
      unique case (code)
         2'h0: thr = 6'h18;
         2'h1: thr = 6'h12;
         2'h2: thr = 6'h1E;
         2'h3: thr = 6'h18;
      endcase
      return thr;
   endfunction : depth_decode

   // levels are dB below full scale, so a smaller number means more noise
   function automatic logic noise_above(input logic [1:0] code,
                                        input logic [7:0] level);
      logic loud_level;
      loud_level = 1'b0;
      unique case (code)
         2'h0: loud_level = 1'b1;
         2'h1: loud_level = level < `NOISE_42_DB;
         2'h2: loud_level = level < `NOISE_54_DB;
         2'h3: loud_level = 1'b1;
      endcase
      return loud_level;
   endfunction : noise_above

   always_comb
   begin
      // zero or reserved threshold counts as always noisy: depth test alone
      loud = noise_above(noise_code, noise); // R11 R13
      deep = depth > depth_decode(depth_code); // R10
      if (loud)
      begin
         ok = deep; // R11
      end
      else
      begin
         ok = asym_ok; // R12
      end
   end

endmodule : duplex_criterion

module echo_suppress_duplex_config
#(
   parameter int ATTACK_CYCLES = `DT_ATTACK_MS * `CLK_KHZ,
   parameter int SLOW_CYCLES = `DT_DECAY_SLOW_MS * `CLK_KHZ,
   parameter int NORMAL_CYCLES = `DT_DECAY_NORMAL_MS * `CLK_KHZ
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic doubletalk,
   input wire logic path_change,
   input wire logic [5:0] acoustic_depth,
   input wire logic [7:0] near_noise,
   input wire logic acoustic_asym_ok,
   input wire logic [5:0] network_depth,
   input wire logic [7:0] far_noise,
   input wire logic network_asym_ok,
   input wire logic network_path_seen,
   input wire logic tx_doubletalk_decay_rate,
   input wire logic rx_doubletalk_decay_rate,
   output logic [4:0] tx_suppress_atten_db,
   output logic low_path_change_sensitivity,
   output logic [4:0] tx_suppress_threshold_db,
   output logic [4:0] tx_suppress_bias_db,
   output logic [4:0] tx_dt_atten_db,
   output logic [3:0] rx_dt_atten_db,
   output logic [4:0] rx_gain_half_db,
   output logic [4:0] tx_gain_half_db,
   output logic network_canceller_enable,
   output logic full_duplex_permit,
   output logic half_duplex_fallback
);
   echo_duplex_pkg::cfg_state_t state;
   echo_duplex_pkg::cfg_state_t next_state;
   logic [2:0] tx_level;
   logic [2:0] rx_level;
   logic acoustic_ok;
   logic network_ok;
   logic network_on;

   // reserved codes decode as code zero so nothing odd reaches the DSP
   function automatic logic [4:0] tx_atten_decode(input logic [1:0] code);
      logic [4:0] db;
      db = 5'h12;
      unique case (code)
         2'h0: db = 5'h12;
         2'h1: db = 5'h0C;
         2'h2: db = 5'h18;
         2'h3: db = 5'h12;
      endcase
      return db;
   endfunction : tx_atten_decode

   function automatic logic [4:0] threshold_decode(input logic [1:0] code);
      logic [4:0] db;
      db = 5'h0F;
      unique case (code)
         2'h0: db = 5'h0F;
         2'h1: db = 5'h0C;
         2'h2: db = 5'h09;
         2'h3: db = 5'h12;
      endcase
      return db;
   endfunction : threshold_decode

   function automatic logic [4:0] bias_decode(input logic [1:0] code);
      logic [4:0] db;
      db = 5'h12;
      unique case (code)
         2'h0: db = 5'h12;
         2'h1: db = 5'h0F;
         2'h2: db = 5'h15;
         2'h3: db = 5'h12;
      endcase
      return db;
   endfunction : bias_decode

   // gain in half-dB units so 9.5 dB is exact
   function automatic logic [4:0] gain_decode(input logic [1:0] code);
      logic [4:0] half_db;
      half_db = 5'h00;
      unique case (code)
         2'h0: half_db = 5'h00;
         2'h1: half_db = 5'h0C;
         2'h2: half_db = 5'h13;
         2'h3: half_db = 5'h18;
      endcase
      return half_db;
   endfunction : gain_decode

   doubletalk_ramp
   #(
      .STEPS(`TX_DT_STEPS),
      .ATTACK_CYCLES(ATTACK_CYCLES),
      .SLOW_CYCLES(SLOW_CYCLES),
      .NORMAL_CYCLES(NORMAL_CYCLES)
   )
   tx_ramp
   (
      .clk(clk),
      .rst_n(rst_n),
      .engage(doubletalk),
      .target(state.supp.tx_doubletalk_atten),
      .normal_rate(tx_doubletalk_decay_rate),
      .level(tx_level)
   );

   doubletalk_ramp
   #(
      .STEPS(`RX_DT_STEPS),
      .ATTACK_CYCLES(ATTACK_CYCLES),
      .SLOW_CYCLES(SLOW_CYCLES),
      .NORMAL_CYCLES(NORMAL_CYCLES)
   )
   rx_ramp
   (
      .clk(clk),
      .rst_n(rst_n),
      .engage(doubletalk),
      .target({1'b0, state.supp.rx_doubletalk_atten}),
      .normal_rate(rx_doubletalk_decay_rate),
      .level(rx_level)
   );

   duplex_criterion acoustic_criterion
   (
      .depth_code(state.dup.acoustic_depth_threshold), // R10
      .noise_code(state.dup.acoustic_noise_threshold), // R11 R13
      .depth(acoustic_depth),
      .noise(near_noise),
      .asym_ok(acoustic_asym_ok), // R12
      .ok(acoustic_ok)
   );

   duplex_criterion network_criterion
   (
      .depth_code(state.dup.network_depth_threshold), // R14
      .noise_code(state.dup.network_noise_threshold), // R15
      .depth(network_depth),
      .noise(far_noise),
      .asym_ok(network_asym_ok), // R15
      .ok(network_ok)
   );

   // auto-disable only armed by a nonzero network threshold
   assign network_on = (state.dup.network_noise_threshold == `NOISE_ZERO)
      || network_path_seen; // R16

   always_comb
   begin
      next_state = state;
      if (wr && addr == `REG_SUPPRESSION && wdata[3:0] == `SEL_SUPPRESSION) // R21
      begin
         next_state.supp.tx_suppress_atten = wdata[`TX_SUPPRESS_ATTEN_LSB +: 2];
         next_state.supp.path_change_sensitivity = wdata[`PATH_CHANGE_SENS_BIT];
         next_state.supp.tx_doubletalk_atten = wdata[`TX_DT_ATTEN_LSB +: 3];
         next_state.supp.rx_doubletalk_atten = wdata[`RX_DT_ATTEN_LSB +: 2];
         next_state.supp.tx_suppress_threshold = wdata[`TX_SUPPRESS_THR_LSB +: 2];
         next_state.supp.tx_suppress_bias = wdata[`TX_SUPPRESS_BIAS_LSB +: 2];
      end
      if (wr && addr == `REG_DUPLEX && wdata[3:0] == `SEL_DUPLEX) // R21
      begin
         next_state.dup.acoustic_depth_threshold = wdata[`ACOUSTIC_DEPTH_LSB +: 2];
         next_state.dup.acoustic_noise_threshold = wdata[`ACOUSTIC_NOISE_LSB +: 2];
         next_state.dup.network_depth_threshold = wdata[`NETWORK_DEPTH_LSB +: 2];
         next_state.dup.network_noise_threshold = wdata[`NETWORK_NOISE_LSB +: 2];
         next_state.dup.rx_analog_gain = wdata[`RX_GAIN_LSB +: 2];
         next_state.dup.tx_analog_gain = wdata[`TX_GAIN_LSB +: 2];
      end
      // unmapped addresses read as zero
      if (rd && addr == `REG_SUPPRESSION)
      begin
         next_state.rdata = {state.supp, `SEL_SUPPRESSION};
      end
      else if (rd && addr == `REG_DUPLEX)
      begin
         next_state.rdata = {state.dup, `SEL_DUPLEX};
      end
      else
      begin
         next_state.rdata = 16'h0000;
      end
      next_state.tx_suppress_atten_db =
         tx_atten_decode(state.supp.tx_suppress_atten); // R01
      next_state.low_sensitivity = state.supp.path_change_sensitivity; // R02
      next_state.tx_suppress_threshold_db =
         threshold_decode(state.supp.tx_suppress_threshold); // R07
      next_state.tx_suppress_bias_db =
         bias_decode(state.supp.tx_suppress_bias); // R08
      next_state.tx_dt_atten_db = 5'(tx_level) * 5'h03; // R05
      next_state.rx_dt_atten_db = 4'(rx_level) * 4'h3; // R06
      next_state.rx_gain_half_db = gain_decode(state.dup.rx_analog_gain); // R18
      next_state.tx_gain_half_db = gain_decode(state.dup.tx_analog_gain); // R19
      next_state.network_canceller_enable = network_on; // R16
      // a disabled network canceller drops out of the decision
      next_state.half_duplex_fallback =
         path_change && !state.supp.path_change_sensitivity; // R03
      next_state.full_duplex_permit = acoustic_ok
         && (network_ok || !network_on) // R14
         && !(path_change && !state.supp.path_change_sensitivity); // R03 R04
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= '0; // R09
      end
      else
      begin
         state <= next_state;
      end
   end

   assign rdata = state.rdata;
   assign tx_suppress_atten_db = state.tx_suppress_atten_db;
   assign low_path_change_sensitivity = state.low_sensitivity;
   assign tx_suppress_threshold_db = state.tx_suppress_threshold_db;
   assign tx_suppress_bias_db = state.tx_suppress_bias_db;
   assign tx_dt_atten_db = state.tx_dt_atten_db;
   assign rx_dt_atten_db = state.rx_dt_atten_db;
   assign rx_gain_half_db = state.rx_gain_half_db;
   assign tx_gain_half_db = state.tx_gain_half_db;
   assign network_canceller_enable = state.network_canceller_enable;
   assign full_duplex_permit = state.full_duplex_permit;
   assign half_duplex_fallback = state.half_duplex_fallback;

endmodule : echo_suppress_duplex_config

// ==== echo_duplex_consts.svh ====
// register offsets, field layouts, reset values and timing for the echo/duplex config bank
//
// Overview of operation
// (R01) bits 15-14 pick tx suppression attenuation
// (R02) bit 13 picks path-change detector sensitivity
// (R03) high sensitivity falls back to half-duplex
// (R04) low sensitivity stays full-duplex during change
// (R05) bits 12-10 tx double-talk attenuation, 3 dB
// (R06) bits 9-8 rx double-talk attenuation, 3 dB
// (R07) bits 7-6 tx suppressor depth threshold
// (R08) bits 5-4 tx suppressor bias
// (R09) reset clears every field to code zero
// (R10) bits 15-14 acoustic depth threshold gate
// (R11) bits 13-12 acoustic noise threshold selects criterion
// (R12) quiet near end uses asymptotic estimate
// (R13) zero noise threshold uses depth only
// (R14) bits 11-10 network depth threshold gate
// (R15) bits 9-8 network noise threshold, same logic
// (R16) nonzero network threshold auto-disables unused canceller
// (R17) host sets nonzero network threshold when unsure
// (R18) bits 7-6 receive analog gain select
// (R19) bits 5-4 transmit analog gain select
// (R20) double-talk attack 40 ms, decay by rate
// (R21) low nibble selector must match to write
// (R22) host never writes reserved codes
`ifndef ECHO_DUPLEX_CONSTS_SVH
`define ECHO_DUPLEX_CONSTS_SVH

`define REG_SUPPRESSION 4'h3
`define REG_DUPLEX 4'h4
`define SEL_SUPPRESSION 4'h6
`define SEL_DUPLEX 4'h8
`define FIELD_RESET 12'h000

`define TX_SUPPRESS_ATTEN_LSB 14
`define PATH_CHANGE_SENS_BIT 13
`define TX_DT_ATTEN_LSB 10
`define RX_DT_ATTEN_LSB 8
`define TX_SUPPRESS_THR_LSB 6
`define TX_SUPPRESS_BIAS_LSB 4
`define ACOUSTIC_DEPTH_LSB 14
`define ACOUSTIC_NOISE_LSB 12
`define NETWORK_DEPTH_LSB 10
`define NETWORK_NOISE_LSB 8
`define RX_GAIN_LSB 6
`define TX_GAIN_LSB 4

`define NOISE_ZERO 2'h0
`define NOISE_42_DB 8'h2A
`define NOISE_54_DB 8'h36

`define CLK_KHZ 25000
`define DT_ATTACK_MS 40
`define DT_DECAY_SLOW_MS 1000
`define DT_DECAY_NORMAL_MS 100
`define TX_DT_STEPS 7
`define RX_DT_STEPS 3

`endif

// ==== echo_duplex_pkg.sv ====
// types shared by the echo/duplex configuration bank
package echo_duplex_pkg;

   typedef struct packed {
      logic [1:0] tx_suppress_atten;
      logic path_change_sensitivity;
      logic [2:0] tx_doubletalk_atten;
      logic [1:0] rx_doubletalk_atten;
      logic [1:0] tx_suppress_threshold;
      logic [1:0] tx_suppress_bias;
   } suppression_config_t;

   typedef struct packed {
      logic [1:0] acoustic_depth_threshold;
      logic [1:0] acoustic_noise_threshold;
      logic [1:0] network_depth_threshold;
      logic [1:0] network_noise_threshold;
      logic [1:0] rx_analog_gain;
      logic [1:0] tx_analog_gain;
   } duplex_criteria_gain_t;

   typedef struct packed {
      logic [24:0] count;
      logic [2:0] level;
   } ramp_state_t;

   typedef struct packed {
      suppression_config_t supp;
      duplex_criteria_gain_t dup;
      logic [15:0] rdata;
      logic [4:0] tx_suppress_atten_db;
      logic low_sensitivity;
      logic [4:0] tx_suppress_threshold_db;
      logic [4:0] tx_suppress_bias_db;
      logic [4:0] tx_dt_atten_db;
      logic [3:0] rx_dt_atten_db;
      logic [4:0] rx_gain_half_db;
      logic [4:0] tx_gain_half_db;
      logic network_canceller_enable;
      logic full_duplex_permit;
      logic half_duplex_fallback;
   } cfg_state_t;

endpackage : echo_duplex_pkg

// ==== echo_config_properties.sv ====
// concurrent checks on the ports of the echo/duplex configuration bank
`timescale 1ns/10ps
module echo_config_properties
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [3:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic path_change,
   input wire logic network_path_seen,
   input wire logic [4:0] tx_suppress_atten_db,
   input wire logic low_path_change_sensitivity,
   input wire logic [4:0] tx_suppress_threshold_db,
   input wire logic [4:0] tx_suppress_bias_db,
   input wire logic [4:0] tx_dt_atten_db,
   input wire logic [3:0] rx_dt_atten_db,
   input wire logic [4:0] rx_gain_half_db,
   input wire logic [4:0] tx_gain_half_db,
   input wire logic network_canceller_enable,
   input wire logic full_duplex_permit,
   input wire logic half_duplex_fallback
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // decoded outputs lag release by one edge; the gate below waits two
   logic [1:0] rst_hist;
   always_ff @(posedge clk)
      rst_hist <= {rst_hist[0], rst_n};

   rd_idle_zero_a: assert property (!rd |=> rdata == 16'h0000)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (rd && addr != 4'h3 && addr != 4'h4 |=>
      rdata == 16'h0000)
      else $error("unmapped read returned data");
   sel_readback_a: assert property (rd && (addr == 4'h3 || addr == 4'h4) |=>
      rdata[3:0] == (($past(addr) == 4'h3) ? 4'h6 : 4'h8))
      else $error("selector missing in read data");
   supp_codes_a: assert property (&rst_hist |->
      tx_suppress_atten_db inside {5'h12, 5'h0C, 5'h18})
      else $error("suppression attenuation off the code list");
   thr_bias_a: assert property (&rst_hist |->
      tx_suppress_threshold_db inside {5'h0F, 5'h0C, 5'h09, 5'h12}
      && tx_suppress_bias_db inside {5'h12, 5'h0F, 5'h15})
      else $error("threshold or bias off the code list");
   dt_range_a: assert property (tx_dt_atten_db % 3 == 0 && tx_dt_atten_db <= 5'h15
      && rx_dt_atten_db % 3 == 0 && rx_dt_atten_db <= 4'h9)
      else $error("double-talk attenuation off its steps");
   gain_codes_a: assert property (
      rx_gain_half_db inside {5'h00, 5'h0C, 5'h13, 5'h18}
      && tx_gain_half_db inside {5'h00, 5'h0C, 5'h13, 5'h18})
      else $error("analog gain off the code list");
   ramp_step_a: assert property ($changed(tx_dt_atten_db) |->
      tx_dt_atten_db == $past(tx_dt_atten_db) + 5'h03
      || tx_dt_atten_db + 5'h03 == $past(tx_dt_atten_db))
      else $error("double-talk ramp jumped more than one step");
   sens_write_a: assert property (wr && addr == 4'h3 && wdata[3:0] == 4'h6 |->
      ##2 low_path_change_sensitivity == $past(wdata[13], 2))
      else $error("sensitivity bit not taken from write");
   fallback_a: assert property (&rst_hist && path_change && !$past(wr) |=>
      half_duplex_fallback == !$past(low_path_change_sensitivity))
      else $error("path change fallback wrong for sensitivity");
   fallback_half_a: assert property (half_duplex_fallback |-> !full_duplex_permit)
      else $error("full duplex permitted during fallback");
   canceller_on_a: assert property (&rst_hist && network_path_seen |=>
      network_canceller_enable)
      else $error("network canceller off with path present");
endmodule : echo_config_properties

bind echo_suppress_duplex_config echo_config_properties u_echo_config_properties (.clk, .rst_n,
   .addr, .wdata, .wr, .rd, .rdata, .path_change, .network_path_seen, .tx_suppress_atten_db,
   .low_path_change_sensitivity, .tx_suppress_threshold_db, .tx_suppress_bias_db,
   .tx_dt_atten_db, .rx_dt_atten_db, .rx_gain_half_db, .tx_gain_half_db,
   .network_canceller_enable, .full_duplex_permit, .half_duplex_fallback);

// ==== host_bus_model.sv ====
// host side model: one register access at a time on the plain port
`timescale 1ns/10ps
module host_bus_model
(
   input wire logic clk,
   input wire logic [15:0] rdata,
   output logic [3:0] addr,
   output logic [15:0] wdata,
   output logic wr,
   output logic rd
);
   initial
   begin
      addr = 4'h0;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
   end
   // callers keep reserved codes out of every field that a matching selector writes
   task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      // idle bus must not keep showing the last word
      wdata <= ~d;
   endtask : write_reg
   task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : read_reg
endmodule : host_bus_model

// ==== tb_top.sv ====
// self-checking bench for the echo suppression and duplex criteria bank
`timescale 1ns/10ps
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, w, rv;
   logic wr, rd, dt = 1'b0, pc = 1'b0, a_ok = 1'b0, n_ok = 1'b0, seen = 1'b0;
   logic tx_rate = 1'b0, rx_rate = 1'b0;
   logic [5:0] a_dep = 6'h00, n_dep = 6'h00;
   logic [7:0] n_near = 8'h00, n_far = 8'h00;
   logic [4:0] att, thr, bias, tx_dt, rx_g, tx_g;
   logic [3:0] rx_dt;
   logic sens, n_en, permit, fallback;
   logic [1:0] c;
   int checked = 0, err_total = 0, cycles = 0;
   logic [4:0] att_t [3] = '{5'h12, 5'h0C, 5'h18};
   logic [4:0] thr_t [4] = '{5'h0F, 5'h0C, 5'h09, 5'h12};
   logic [4:0] bias_t [3] = '{5'h12, 5'h0F, 5'h15};
   logic [4:0] gain_t [4] = '{5'h00, 5'h0C, 5'h13, 5'h18};
   logic [5:0] dep_t [3] = '{6'h18, 6'h12, 6'h1E};

   always #20 clk = ~clk;

   host_bus_model u_host_bus_model (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));
   // short ramp counts keep the run brief: tx step 2, rx step 4 cycles
   echo_suppress_duplex_config #(.ATTACK_CYCLES(14), .SLOW_CYCLES(70), .NORMAL_CYCLES(28))
   u_echo_suppress_duplex_config (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .doubletalk(dt), .path_change(pc),
      .acoustic_depth(a_dep), .near_noise(n_near), .acoustic_asym_ok(a_ok),
      .network_depth(n_dep), .far_noise(n_far), .network_asym_ok(n_ok),
      .network_path_seen(seen), .tx_doubletalk_decay_rate(tx_rate),
      .rx_doubletalk_decay_rate(rx_rate), .tx_suppress_atten_db(att),
      .low_path_change_sensitivity(sens), .tx_suppress_threshold_db(thr),
      .tx_suppress_bias_db(bias), .tx_dt_atten_db(tx_dt), .rx_dt_atten_db(rx_dt),
      .rx_gain_half_db(rx_g), .tx_gain_half_db(tx_g), .network_canceller_enable(n_en),
      .full_duplex_permit(permit), .half_duplex_fallback(fallback));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask : settle

   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         err_total++;
         end_of_test();
      end
   end

   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      u_host_bus_model.read_reg(4'h3, rv);
      check(rv, 16'h0006);
      u_host_bus_model.read_reg(4'h4, rv);
      check(rv, 16'h0008);
      check({att, thr, bias, 1'b0}, 16'h93E4);
      for (int i = 0; i < 4; i++)
      begin
         c = (i == 3) ? 2'h0 : 2'(i);
         w = {c, 1'(i), 3'(i), 2'(i), 2'(i), c, 4'h6};
         u_host_bus_model.write_reg(4'h3, w);
         settle();
         check(16'(att), 16'(att_t[c]));
         check(16'(sens), 16'(i % 2));
         check(16'(thr), 16'(thr_t[i]));
         check(16'(bias), 16'(bias_t[c]));
         u_host_bus_model.read_reg(4'h3, rv);
         check(rv, w);
      end
      u_host_bus_model.write_reg(4'h3, 16'hFFF8);
      u_host_bus_model.write_reg(4'h5, 16'hFFF6);
      u_host_bus_model.read_reg(4'h3, rv);
      check(rv, w);
      u_host_bus_model.read_reg(4'h5, rv);
      check(rv, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         u_host_bus_model.write_reg(4'h4, {8'h00, 2'(i), 2'(3 - i), 4'h8});
         settle();
         check(16'(rx_g), 16'(gain_t[i]));
         check(16'(tx_g), 16'(gain_t[3 - i]));
      end
      u_host_bus_model.write_reg(4'h3, 16'h0006);
      @(posedge clk);
      pc <= 1'b1;
      settle();
      check({fallback, permit}, 16'h0002);
      u_host_bus_model.write_reg(4'h3, 16'h2006);
      settle();
      check(16'(fallback), 16'h0000);
      @(posedge clk);
      pc <= 1'b0;
      for (int k = 0; k < 3; k++)
      begin
         u_host_bus_model.write_reg(4'h4, {2'(k), 2'h0, 2'(k), 6'h00, 4'h8});
         for (int j = 0; j < 3; j++)
         begin
            @(posedge clk);
            a_dep <= dep_t[k] + 6'(j != 1);
            n_dep <= dep_t[k] + 6'(j != 2);
            settle();
            check({n_en, permit}, {14'h0000, 1'b1, 1'(j == 0)});
         end
      end
      u_host_bus_model.write_reg(4'h4, 16'h1108);
      settle();
      check(16'(n_en), 16'h0000);
      for (int j = 0; j < 3; j++)
      begin
         @(posedge clk);
         seen <= 1'b1;
         a_dep <= 6'h0A;
         n_dep <= 6'h0A;
         n_near <= (j == 2) ? 8'h1E : 8'h32;
         n_far <= (j == 2) ? 8'h1E : 8'h32;
         a_ok <= (j != 0);
         n_ok <= (j != 0);
         settle();
         check({n_en, permit}, {14'h0000, 1'b1, 1'(j == 1)});
      end
      @(posedge clk);
      n_near <= 8'h32;
      n_far <= 8'h32;
      u_host_bus_model.write_reg(4'h4, 16'h2208);
      settle();
      check(16'(permit), 16'h0000);
      u_host_bus_model.write_reg(4'h3, 16'h1F06);
      for (int r = 1; r >= 0; r--)
      begin
         @(posedge clk);
         tx_rate <= 1'(r);
         rx_rate <= 1'(r);
         dt <= 1'b1;
         repeat (6) @(posedge clk);
         #1;
         check(16'(tx_dt > 5'h00 && tx_dt < 5'h15), 16'h0001);
         repeat (34) @(posedge clk);
         dt <= 1'b0;
         #1;
         check({tx_dt, rx_dt}, 16'h0159);
         repeat (32) @(posedge clk);
         #1;
         check(16'(tx_dt != 5'h00), 16'(r == 0));
         repeat (60) @(posedge clk);
         #1;
         check({tx_dt, rx_dt}, 16'h0000);
      end
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      check({att, thr, bias, 1'b0}, 16'h93E4);
      u_host_bus_model.read_reg(4'h3, rv);
      check(rv, 16'h0006);
      u_host_bus_model.read_reg(4'h4, rv);
      check(rv, 16'h0008);
      end_of_test();
   end
endmodule : tb_top
